/* File: pwm_trig_pkg.sv */
// Constants for the PWM A/D trigger output block
`default_nettype none
package pwm_trig_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int NUM_CMP = 4;
    localparam int NUM_OUT = 6;
    localparam int SEL_W = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_TRIGGER_OUTPUT_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_TIMING_SELECT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ROUTE_SELECT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;

    // trigger_output_mode fields
    localparam int POS_PROT_EN = 0;
    localparam int POS_VARIABLE = 1;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // timing select: field i sits at bits 4*i+2 .. 4*i
    localparam int TIMING_STRIDE = 4;
    localparam logic [SEL_W-1:0] TIMING_RESET = 3'h0;

    // route_select fields
    localparam int POS_ROUTE_SEL = 0;
    localparam int POS_USE_SECTOR = 3;
    localparam logic [SEL_W-1:0] ROUTE_RESET = 3'h0;

    // status fields
    localparam int POS_STAT_TRIG = 0;
    localparam int POS_STAT_EMG = 8;

    // Timing selection codes
    localparam logic [SEL_W-1:0] TS_OFF = 3'h0;
    localparam logic [SEL_W-1:0] TS_DOWN = 3'h1;
    localparam logic [SEL_W-1:0] TS_UP = 3'h2;
    localparam logic [SEL_W-1:0] TS_UPDOWN = 3'h3;
    localparam logic [SEL_W-1:0] TS_PEAK = 3'h4;
    localparam logic [SEL_W-1:0] TS_BOTTOM = 3'h5;
    localparam logic [SEL_W-1:0] TS_BOTTOM_ALT = 3'h6;
    localparam logic [SEL_W-1:0] TS_PEAK_BOTTOM = 3'h7;

    // Compare value at which up/down timing gives one trigger per period
    localparam logic [CNT_W-1:0] CMP_SINGLE = 16'h0001;
endpackage
`default_nettype wire

/* File: pwm_adc_trigger_output.sv */
// PWM carrier compare trigger generator for A/D start inputs, APB slave
// Operation
// - Timing code 000 gives no trigger whatever the compare matches.
// - Code 001 down-count match, 010 up-count match, 011 either direction.
// - Code 100 peak, 101 and 110 bottom, 111 peak and bottom.
// - Edge-aligned carrier turns down-match into up-match, bottom into peak.
// - Code 011, compare 0x0001, triangular carrier: one trigger per period.
// - Fixed routing: outputs 0 to 3 follow compares 0 to 3.
// - Fixed routing holds outputs 4 and 5 low.
// - Variable routing: only compare 0 trigger, sent to selected output.
// - Variable routing may take the destination from engine sector input.
// - In protection, outputs suppressed unless protection enable bit is 1.
// - Variable routing: destination codes 110 and 111 give no trigger on any output.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pwm_adc_trigger_output
    import pwm_trig_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwm_trig_pkg::ADDR_W-1:0] paddr,
    input wire logic [pwm_trig_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [pwm_trig_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pwm_trig_pkg::CNT_W-1:0] carrier_count,
    input wire logic count_down,
    input wire logic carrier_peak,
    input wire logic carrier_bottom,
    input wire logic edge_aligned,
    input wire logic triangular,
    input wire logic [pwm_trig_pkg::CNT_W-1:0] trigger_compare_0,
    input wire logic [pwm_trig_pkg::CNT_W-1:0] trigger_compare_1,
    input wire logic [pwm_trig_pkg::CNT_W-1:0] trigger_compare_2,
    input wire logic [pwm_trig_pkg::CNT_W-1:0] trigger_compare_3,
    input wire logic emergency_protection,
    input wire logic [pwm_trig_pkg::SEL_W-1:0] engine_sector,
    output logic adc_sync_trigger_0,
    output logic adc_sync_trigger_1,
    output logic adc_sync_trigger_2,
    output logic adc_sync_trigger_3,
    output logic adc_sync_trigger_4,
    output logic adc_sync_trigger_5
);
    import pwm_trig_pkg::*;

    // Timing decode shared by the four compare channels
    function automatic logic timing_hit(
        input logic [SEL_W-1:0] sel,
        input logic dn,
        input logic up,
        input logic pk,
        input logic bt,
        input logic edge_m,
        input logic one_per_period
    );
        logic eff_dn;
        logic eff_bt;
        logic hit;
        eff_dn = edge_m ? up : dn;
        eff_bt = edge_m ? pk : bt;
        unique case (sel)
            TS_OFF: hit = 1'b0;
            TS_DOWN: hit = eff_dn;
            TS_UP: hit = up;
            TS_UPDOWN: hit = one_per_period ? up : (eff_dn | up);
            TS_PEAK: hit = pk;
            TS_BOTTOM: hit = eff_bt;
            TS_BOTTOM_ALT: hit = eff_bt;
            TS_PEAK_BOTTOM: hit = pk | eff_bt;
        endcase
        return hit;
    endfunction

    // One-hot destination for a route code; 110 and 111 select nothing
    function automatic logic [NUM_OUT-1:0] route_onehot(
        input logic [SEL_W-1:0] sel
    );
        logic [NUM_OUT-1:0] oh;
        oh = '0;
        if (sel < SEL_W'(NUM_OUT)) begin
            oh[sel] = 1'b1;
        end
        return oh;
    endfunction

    logic prot_en_r;
    logic variable_r;
    logic [SEL_W-1:0] timing_r [NUM_CMP];
    logic [SEL_W-1:0] route_sel_r;
    logic use_sector_r;
    logic [CNT_W-1:0] prev_count_r;
    logic [NUM_OUT-1:0] trig_r;
    logic [NUM_OUT-1:0] trig_nxt;
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    wire logic [CNT_W-1:0] cmp_val [NUM_CMP];
    wire logic [NUM_CMP-1:0] hit;
    wire logic [NUM_CMP-1:0] dn_match;
    wire logic [NUM_CMP-1:0] up_match;
    wire logic count_moved;
    wire logic setup_phase;
    wire logic wr_access;
    wire logic addr_mode;
    wire logic addr_timing;
    wire logic addr_route;
    wire logic addr_status;
    wire logic addr_ok;
    wire logic gate_off;
    wire logic [SEL_W-1:0] dest_sel;
    wire logic [NUM_OUT-1:0] routed;
    wire logic [DATA_W-1:0] timing_word;

    assign cmp_val[0] = trigger_compare_0;
    assign cmp_val[1] = trigger_compare_1;
    assign cmp_val[2] = trigger_compare_2;
    assign cmp_val[3] = trigger_compare_3;

    // A match counts once, when the counter arrives at the compare value
    assign count_moved = carrier_count != prev_count_r;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
            wire logic eq;
            wire logic single;
            assign eq = count_moved && (carrier_count == cmp_val[gi]);
            assign dn_match[gi] = eq && count_down;
            assign up_match[gi] = eq && !count_down;
            assign single = triangular && (cmp_val[gi] == CMP_SINGLE);
            assign hit[gi] = timing_hit(timing_r[gi], dn_match[gi],
                up_match[gi], carrier_peak, carrier_bottom, edge_aligned,
                single);
        end
    endgenerate

    assign dest_sel = use_sector_r ? engine_sector : route_sel_r;
    assign routed = route_onehot(dest_sel) & {NUM_OUT{hit[0]}};
    assign gate_off = emergency_protection && !prot_en_r;

    always_comb begin
        if (gate_off) begin
            trig_nxt = '0;
        end else if (variable_r) begin
            trig_nxt = routed;
        end else begin
            trig_nxt = {2'b00, hit};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_count_r <= '0;
            trig_r <= '0;
        end else begin
            prev_count_r <= carrier_count;
            trig_r <= trig_nxt;
        end
    end

    assign adc_sync_trigger_0 = trig_r[0];
    assign adc_sync_trigger_1 = trig_r[1];
    assign adc_sync_trigger_2 = trig_r[2];
    assign adc_sync_trigger_3 = trig_r[3];
    assign adc_sync_trigger_4 = trig_r[4];
    assign adc_sync_trigger_5 = trig_r[5];

    // APB decode: zero wait states, read data captured in the setup cycle
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign addr_mode = paddr == OFS_TRIGGER_OUTPUT_MODE;
    assign addr_timing = paddr == OFS_TIMING_SELECT;
    assign addr_route = paddr == OFS_ROUTE_SELECT;
    assign addr_status = paddr == OFS_STATUS;
    assign addr_ok = addr_mode || addr_timing || addr_route || addr_status;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_tw
            assign timing_word[gi*TIMING_STRIDE +: TIMING_STRIDE] =
                {1'b0, timing_r[gi]};
        end
    endgenerate
    assign timing_word[DATA_W-1:NUM_CMP*TIMING_STRIDE] = '0;

    always_comb begin
        rdata_nxt = '0;
        if (addr_mode) begin
            rdata_nxt[POS_PROT_EN] = prot_en_r;
            rdata_nxt[POS_VARIABLE] = variable_r;
        end else if (addr_timing) begin
            rdata_nxt = timing_word;
        end else if (addr_route) begin
            rdata_nxt[POS_ROUTE_SEL +: SEL_W] = route_sel_r;
            rdata_nxt[POS_USE_SECTOR] = use_sector_r;
        end else if (addr_status) begin
            rdata_nxt[POS_STAT_TRIG +: NUM_OUT] = trig_r;
            rdata_nxt[POS_STAT_EMG] = emergency_protection;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (setup_phase && !pwrite) begin
            prdata_r <= rdata_nxt;
        end
    end
    assign prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prot_en_r <= MODE_RESET[POS_PROT_EN];
            variable_r <= MODE_RESET[POS_VARIABLE];
            route_sel_r <= ROUTE_RESET;
            use_sector_r <= 1'b0;
        end else if (wr_access && pstrb[0]) begin
            if (addr_mode) begin
                prot_en_r <= pwdata[POS_PROT_EN];
                variable_r <= pwdata[POS_VARIABLE];
            end
            if (addr_route) begin
                route_sel_r <= pwdata[POS_ROUTE_SEL +: SEL_W];
                use_sector_r <= pwdata[POS_USE_SECTOR];
            end
        end
    end

    generate
        for (gi = 0; gi < NUM_CMP; gi++) begin : g_treg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    timing_r[gi] <= TIMING_RESET;
                end else if (wr_access && addr_timing && pstrb[gi/2]) begin
                    timing_r[gi] <= pwdata[gi*TIMING_STRIDE +: SEL_W];
                end
            end
        end
    endgenerate

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_code_off_quiet: assert property (
        (!gate_off && !variable_r && timing_r[0] == TS_OFF)
        |=> !adc_sync_trigger_0)
        else $error("trigger 0 fired with timing disabled");
    a_down_match: assert property (
        (!gate_off && !variable_r && !edge_aligned && timing_r[1] == TS_DOWN
         && dn_match[1]) |=> adc_sync_trigger_1)
        else $error("down-count match gave no trigger");
    a_peak_bottom: assert property (
        (!gate_off && !variable_r && !edge_aligned
         && timing_r[2] == TS_PEAK_BOTTOM
         && (carrier_peak || carrier_bottom)) |=> adc_sync_trigger_2)
        else $error("peak or bottom gave no trigger");
    a_edge_override: assert property (
        (edge_aligned && timing_r[0] == TS_BOTTOM && !carrier_peak)
        |=> !adc_sync_trigger_0)
        else $error("bottom trigger in edge-aligned mode");
    a_single_period: assert property (
        (triangular && timing_r[0] == TS_UPDOWN && cmp_val[0] == CMP_SINGLE
         && dn_match[0]) |=> !adc_sync_trigger_0)
        else $error("second trigger per period at compare one");
    a_fixed_follow: assert property (
        (!gate_off && !variable_r) |=> trig_r[3:0] == $past(hit))
        else $error("fixed output does not follow its compare");
    a_fixed_high_low: assert property (
        !variable_r |=> (!adc_sync_trigger_4 && !adc_sync_trigger_5))
        else $error("output 4 or 5 high in fixed routing");
    a_route_sel: assert property (
        (!gate_off && variable_r && !use_sector_r && route_sel_r == 3'h5
         && hit[0]) |=> trig_r == 6'h20)
        else $error("routed trigger on wrong output");
    a_sector_route: assert property (
        (!gate_off && variable_r && use_sector_r && engine_sector == 3'h2
         && hit[0]) |=> trig_r == 6'h04)
        else $error("sector routed trigger on wrong output");
    a_emg_block: assert property (
        gate_off |=> trig_r == 6'h00)
        else $error("trigger during protection while disabled");
    a_route_none: assert property (
        (variable_r && dest_sel >= 3'h6) |=> trig_r == 6'h00)
        else $error("trigger for route code 110 or 111");
    a_mode_reserved: assert property (
        (psel && penable && !pwrite && addr_mode) |-> prdata[31:2] == '0)
        else $error("reserved mode bits read nonzero");

    c_fixed_trig: cover property (!variable_r ##1 adc_sync_trigger_3);
    c_var_trig: cover property (variable_r ##1 adc_sync_trigger_4);
    c_emg_pass: cover property (emergency_protection && prot_en_r
        && hit[0] ##1 adc_sync_trigger_0);
    c_edge_mode: cover property (edge_aligned && carrier_peak
        && timing_r[0] == TS_PEAK_BOTTOM);

endmodule // pwm_adc_trigger_output
`default_nettype wire

/* File: adc_trigger_sink.sv */
// Model of the A/D converter start-trigger inputs: counts high cycles
`timescale 1ns/100ps
`default_nettype none
module adc_trigger_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic adc_sync_trigger_0,
    input wire logic adc_sync_trigger_1,
    input wire logic adc_sync_trigger_2,
    input wire logic adc_sync_trigger_3,
    input wire logic adc_sync_trigger_4,
    input wire logic adc_sync_trigger_5,
    output logic [47:0] hits
);
    logic [5:0] start;
    logic [47:0] hits_r;
    assign start = {adc_sync_trigger_5, adc_sync_trigger_4,
        adc_sync_trigger_3, adc_sync_trigger_2, adc_sync_trigger_1,
        adc_sync_trigger_0};
    assign hits = hits_r;
    // Counting high cycles, not edges, so a stuck trigger shows up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hits_r <= '0;
        end else if (clear) begin
            hits_r <= '0;
        end else begin
            for (int i = 0; i < 6; i++) begin
                hits_r[8*i +: 8] <= hits_r[8*i +: 8] + 8'(start[i]);
            end
        end
    end
endmodule // adc_trigger_sink
`default_nettype wire

/* File: pwm_adc_trigger_output_tb.sv */
// Self-checking testbench for the PWM A/D trigger output block
`timescale 1ns/100ps
`default_nettype none
module pwm_adc_trigger_output_tb;
    import pwm_trig_pkg::*;
    localparam logic [1:0] EXP_TRI [8] = '{2'b00, 2'b01, 2'b10, 2'b11,
        2'b10, 2'b01, 2'b01, 2'b11};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, clear;
    logic count_down, carrier_peak, carrier_bottom, edge_aligned, triangular;
    logic emergency_protection;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [CNT_W-1:0] carrier_count, trigger_compare_0, trigger_compare_1;
    logic [CNT_W-1:0] trigger_compare_2, trigger_compare_3;
    logic [SEL_W-1:0] engine_sector, dest;
    logic adc_sync_trigger_0, adc_sync_trigger_1, adc_sync_trigger_2;
    logic adc_sync_trigger_3, adc_sync_trigger_4, adc_sync_trigger_5;
    logic [47:0] hits, up, exp_hits;
    int mismatches, cmp_count;

    pwm_adc_trigger_output dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .carrier_count,
        .count_down, .carrier_peak, .carrier_bottom, .edge_aligned,
        .triangular, .trigger_compare_0, .trigger_compare_1,
        .trigger_compare_2, .trigger_compare_3, .emergency_protection,
        .engine_sector, .adc_sync_trigger_0, .adc_sync_trigger_1,
        .adc_sync_trigger_2, .adc_sync_trigger_3, .adc_sync_trigger_4,
        .adc_sync_trigger_5);
    adc_trigger_sink sink_u (.pclk, .presetn, .clear, .adc_sync_trigger_0,
        .adc_sync_trigger_1, .adc_sync_trigger_2, .adc_sync_trigger_3,
        .adc_sync_trigger_4, .adc_sync_trigger_5, .hits);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input string what, input logic [47:0] e,
        input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask

    task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(what, 48'(e), 48'(rd));
    endtask

    task automatic step(input logic [CNT_W-1:0] c, input logic d, p, b);
        {carrier_count, count_down} <= {c, d};
        {carrier_peak, carrier_bottom} <= {p, b};
        @(posedge pclk);
    endtask

    // One triangular carrier period 0..8..0; up holds the up-half counts
    task automatic period;
        clear <= 1'b1;
        @(posedge pclk);
        clear <= 1'b0;
        for (int i = 1; i <= 8; i++) step(16'(i), 1'b0, i == 8, 1'b0);
        step(16'h0008, 1'b0, 1'b0, 1'b0);
        @(posedge pclk);
        up = hits;
        for (int i = 7; i >= 0; i--) step(16'(i), 1'b1, 1'b0, i == 0);
        step(16'h0000, 1'b1, 1'b0, 1'b0);
        @(posedge pclk);
    endtask

    task report_and_stop;
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        mismatches = 0;
        cmp_count = 0;
        {presetn, psel, penable, pwrite, clear, count_down, carrier_peak} = '0;
        {carrier_bottom, edge_aligned, emergency_protection} = '0;
        {paddr, pwdata, carrier_count, engine_sector} = '0;
        triangular = 1'b1;
        pstrb = 4'hF;
        trigger_compare_0 = 16'h0003;
        {trigger_compare_1, trigger_compare_2} = {2{16'h00FF}};
        trigger_compare_3 = 16'h00FF;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("mode_reset", OFS_TRIGGER_OUTPUT_MODE, 32'h0);
        apb(1'b1, OFS_TRIGGER_OUTPUT_MODE, 32'hFFFFFFFF);
        rdchk("mode_bits", OFS_TRIGGER_OUTPUT_MODE, 32'h00000003);
        rdchk("unmapped_data", 8'h10, 32'h0);
        check("unmapped_err", 48'h1, 48'(err));
        apb(1'b1, OFS_TRIGGER_OUTPUT_MODE, 32'h0);
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, OFS_TIMING_SELECT, 32'(c));
            period();
            check("up_trig", 48'(EXP_TRI[c][1]), 48'(up[7:0]));
            check("down_trig", 48'(EXP_TRI[c][0]),
                48'(hits[7:0] - up[7:0]));
        end
        edge_aligned <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFS_TIMING_SELECT, 32'((k == 0) ? TS_DOWN : TS_BOTTOM));
            period();
            check("edge_up", 48'h1, 48'(up[7:0]));
            check("edge_down", 48'h0, 48'(hits[7:0] - up[7:0]));
        end
        edge_aligned <= 1'b0;
        trigger_compare_0 <= CMP_SINGLE;
        apb(1'b1, OFS_TIMING_SELECT, 32'(TS_UPDOWN));
        period();
        check("single_per_period", 48'h1, 48'(hits[7:0]));
        // Without a triangular carrier both directions fire at compare one
        triangular <= 1'b0;
        period();
        check("two_per_period", 48'h2, 48'(hits[7:0]));
        triangular <= 1'b1;
        $display("test timing done");
        trigger_compare_0 <= 16'h0003;
        trigger_compare_1 <= 16'h0004;
        trigger_compare_2 <= 16'h0005;
        trigger_compare_3 <= 16'h0006;
        // Up, down, peak/bottom and up timing on compares 0 to 3
        apb(1'b1, OFS_TIMING_SELECT, 32'h00002712);
        period();
        check("fixed_route", 48'h000001020101, hits);
        apb(1'b1, OFS_TRIGGER_OUTPUT_MODE, 32'h00000002);
        // Sector and route code always disagree, so the wrong source shows
        for (int k = 0; k < 16; k++) begin
            dest = 3'(k);
            engine_sector <= (k >= 8) ? dest : 3'h5 - dest;
            apb(1'b1, OFS_ROUTE_SELECT, (k >= 8) ?
                {28'h0, 1'b1, (dest < 3'h6) ? 3'h5 - dest : 3'h1} :
                32'(dest));
            period();
            exp_hits = (dest < 3'h6) ? (48'h1 << (8 * dest)) : 48'h0;
            check("var_route", exp_hits, hits);
        end
        $display("test routing done");
        apb(1'b1, OFS_TRIGGER_OUTPUT_MODE, 32'h0);
        emergency_protection <= 1'b1;
        period();
        check("emg_gated", 48'h0, hits);
        apb(1'b1, OFS_TRIGGER_OUTPUT_MODE, 32'h00000001);
        period();
        check("emg_enabled", 48'h000001020101, hits);
        $display("test protection done");
        // Reset in mid-run must bring the mode bits back to zero
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("mode_rerst", OFS_TRIGGER_OUTPUT_MODE, 32'h0);
        $display("test reset done");
        report_and_stop();
    end
endmodule // pwm_adc_trigger_output_tb
`default_nettype wire
